// ### hdl/lld_regs.sv
// register group for indicator pin 3 source, clock pin owner and line levels
// assumes a single-cycle register port; wake, carrier sense and interrupt pin inputs are synchronised here
// Function
// - pin 3 source code is fixed at 0 normal; codes 2 wake, 3/5/6 carrier sense, 4 interrupt, 7 high are decoded but never set.
// - status bit 0 is read-only, 0 for clock output, 1 for second indicator.
// - mdi minus-one code sits at level a bits 11-6, reset 30h.
// - mdix plus-one code sits at level b bits 11-6, reset 10h.
// - mdi plus-one code sits at level b bits 5-0, reset 10h.
// - zero symbol code sits at level a bits 5-0, writable, reset 0.
// - io config bit 6 chooses clock output (0) or second indicator (1).
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module lld_regs
    import lld_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [9:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic ind3_normal_i,
    input wire logic wol_i,
    input wire logic crs_i,
    input wire logic irq_i,
    input wire logic ref_clock_25m_i,
    input wire logic [1:0] symbol_i,
    input wire logic mdix_i,
    output logic indicator_pin_3_o,
    output logic ref_clock_25m_output_o,
    output logic ref_clock_25m_output_oe_o,
    output logic [5:0] dac_code_o
);
    typedef struct packed {
        logic [15:0] io_cfg;
        logic [15:0] ind3_cfg;
        logic [15:0] clk_status;
        logic [15:0] level_a;
        logic [15:0] level_b;
        logic [15:0] rdata;
        logic [5:0] dac;
        logic ind3;
        logic [1:0] wol_s;
        logic [1:0] crs_s;
        logic [1:0] irq_s;
    } lld_state_type;

    lld_state_type r;
    lld_state_type next_r;
    logic [5:0] sel_code;
    logic [5:0] minus_mdix;
    logic [2:0] indicator3_source_select;
    logic ref_clock_pin_owner_select;

    function automatic logic [15:0] read_mux(input logic [9:0] a, input lld_state_type s);
        unique case (a)
            ADDR_IO_CFG: read_mux = s.io_cfg;
            ADDR_IND3_CFG: read_mux = s.ind3_cfg;
            ADDR_CLK_STATUS: read_mux = s.clk_status;
            ADDR_LEVEL_A: read_mux = s.level_a;
            ADDR_LEVEL_B: read_mux = s.level_b;
            default: read_mux = 16'h0000;
        endcase
    endfunction : read_mux

    assign indicator3_source_select = r.ind3_cfg[2:0];
    assign ref_clock_pin_owner_select = r.io_cfg[IO_OWNER_BIT];
    assign minus_mdix = {r.level_a[13:12], r.level_b[15:12]};

    lld_level_sel u_sel (
        .symbol_i(symbol_i),
        .mdix_i(mdix_i),
        .zero_code_i(r.level_a[5:0]),
        .plus_mdi_i(r.level_b[5:0]),
        .plus_mdix_i(r.level_b[11:6]),
        .minus_mdi_i(r.level_a[11:6]),
        .minus_mdix_i(minus_mdix),
        .code_o(sel_code)
    );

    always_comb begin
        next_r = r;
        next_r.wol_s = {r.wol_s[0], wol_i};
        next_r.crs_s = {r.crs_s[0], crs_i};
        next_r.irq_s = {r.irq_s[0], irq_i};
        next_r.rdata = 16'h0000;
        if (rd_i) begin
            next_r.rdata = read_mux(addr_i, r);
        end
        if (wr_i) begin
            unique case (addr_i)
                ADDR_IO_CFG: next_r.io_cfg = wdata_i & (16'h0001 << IO_OWNER_BIT);
                // pin 3 source field reads fixed; bits 5-3 writable
                ADDR_IND3_CFG: next_r.ind3_cfg = {10'h000, wdata_i[5:3], r.ind3_cfg[2:0]};
                ADDR_CLK_STATUS: next_r.clk_status[15:1] = wdata_i[15:1];
                ADDR_LEVEL_A: next_r.level_a = {2'h0, wdata_i[13:0]};
                ADDR_LEVEL_B: next_r.level_b = wdata_i;
                default: next_r.level_b = r.level_b;
            endcase
        end
        next_r.clk_status[0] = ref_clock_pin_owner_select;
        unique case (indicator3_source_select)
            SRC_NORMAL: next_r.ind3 = ind3_normal_i;
            SRC_WOL: next_r.ind3 = r.wol_s[1];
            SRC_CRS_A, SRC_CRS_B, SRC_CRS_C: next_r.ind3 = r.crs_s[1];
            SRC_IRQ: next_r.ind3 = r.irq_s[1];
            SRC_HIGH: next_r.ind3 = 1'b1;
            default: next_r.ind3 = 1'b0;
        endcase
        next_r.dac = sel_code;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.io_cfg <= RST_IO_CFG;
            r.ind3_cfg <= RST_IND3_CFG;
            r.clk_status <= RST_CLK_STATUS;
            r.level_a <= RST_LEVEL_A;
            r.level_b <= RST_LEVEL_B;
        end else begin
            r <= next_r;
        end
    end

    assign rdata_o = r.rdata;
    assign indicator_pin_3_o = r.ind3;
    assign dac_code_o = r.dac;
    assign ref_clock_25m_output_o = ref_clock_25m_i & ~ref_clock_pin_owner_select;
    assign ref_clock_25m_output_oe_o = ~ref_clock_pin_owner_select;

    // status follows select in one cycle
    property p_status_follow;
        @(posedge ref_clk_i) disable iff (rst_i)
        ##1 r.clk_status[0] == $past(r.io_cfg[IO_OWNER_BIT]);
    endproperty
    a_status_follow: assert property (p_status_follow) else $error("status bit stale");
    // dac code tracks symbol and state
    property p_dac;
        @(posedge ref_clk_i) disable iff (rst_i)
        (symbol_i == SYM_MINUS && mdix_i) |=> dac_code_o == $past(minus_mdix);
    endproperty
    a_dac: assert property (p_dac) else $error("dac minus mdix wrong");
    property p_zero;
        @(posedge ref_clk_i) disable iff (rst_i)
        (symbol_i == SYM_ZERO) |=> dac_code_o == $past(r.level_a[5:0]);
    endproperty
    a_zero: assert property (p_zero) else $error("dac zero code wrong");
    property p_high;
        @(posedge ref_clk_i) disable iff (rst_i)
        (indicator3_source_select == SRC_HIGH) |=> indicator_pin_3_o;
    endproperty
    a_high: assert property (p_high) else $error("pin 3 not high");
    property p_rd;
        @(posedge ref_clk_i) disable iff (rst_i)
        (rd_i && addr_i == ADDR_LEVEL_B && !wr_i) |=> rdata_o == $past(r.level_b);
    endproperty
    a_rd: assert property (p_rd) else $error("level b read wrong");
    property p_normal;
        @(posedge ref_clk_i) disable iff (rst_i)
        (indicator3_source_select == SRC_NORMAL) |=> indicator_pin_3_o == $past(ind3_normal_i);
    endproperty
    a_normal: assert property (p_normal) else $error("pin 3 not following source");
    property p_ind3_write;
        @(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == ADDR_IND3_CFG) |=> r.ind3_cfg[2:0] == SRC_NORMAL
            && r.ind3_cfg[5:3] == $past(wdata_i[5:3]) && r.ind3_cfg[15:6] == '0;
    endproperty
    a_ind3_write: assert property (p_ind3_write) else $error("pin 3 config write wrong");
    sequence s_owner_write;
        wr_i && addr_i == ADDR_IO_CFG;
    endsequence
    sequence s_pin_released;
        ref_clock_25m_output_oe_o == !$past(wdata_i[IO_OWNER_BIT]);
    endsequence
    sequence s_status_updated;
        r.clk_status[0] == $past(wdata_i[IO_OWNER_BIT], 2);
    endsequence
    property p_owner_write;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_owner_write |=> s_pin_released ##1 s_status_updated;
    endproperty
    a_owner_write: assert property (p_owner_write) else $error("owner select not applied");
    property p_status_ro;
        @(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == ADDR_CLK_STATUS) |=>
            r.clk_status[0] == $past(r.io_cfg[IO_OWNER_BIT])
            && r.clk_status[15:1] == $past(wdata_i[15:1]);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write wrong");
    property p_level_a_write;
        @(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && addr_i == ADDR_LEVEL_A) |=>
            r.level_a[5:0] == $past(wdata_i[5:0]) && r.level_a[15:14] == 2'h0;
    endproperty
    a_level_a_write: assert property (p_level_a_write) else $error("level a write");
    property p_minus_mdi;
        @(posedge ref_clk_i) disable iff (rst_i)
        (symbol_i == SYM_MINUS && !mdix_i) |=> dac_code_o == $past(r.level_a[11:6]);
    endproperty
    a_minus_mdi: assert property (p_minus_mdi) else $error("dac minus mdi wrong");
    property p_plus_mdix;
        @(posedge ref_clk_i) disable iff (rst_i)
        (symbol_i == SYM_PLUS && mdix_i) |=> dac_code_o == $past(r.level_b[11:6]);
    endproperty
    a_plus_mdix: assert property (p_plus_mdix) else $error("dac plus mdix wrong");
    property p_plus_mdi;
        @(posedge ref_clk_i) disable iff (rst_i)
        (symbol_i == SYM_PLUS && !mdix_i) |=> dac_code_o == $past(r.level_b[5:0]);
    endproperty
    a_plus_mdi: assert property (p_plus_mdi) else $error("dac plus mdi wrong");
    property p_minus_split;
        @(posedge ref_clk_i) disable iff (rst_i)
        (symbol_i == SYM_MINUS && mdix_i) |=> dac_code_o[5:4] == $past(r.level_a[13:12])
            && dac_code_o[3:0] == $past(r.level_b[15:12]);
    endproperty
    a_minus_split: assert property (p_minus_split) else $error("dac minus split wrong");
endmodule : lld_regs

// ### hdl/lld_pkg.sv
// constants for the indicator 3 pin and line driver level register group
// assumes a 16-bit register port with word offsets
package lld_pkg;
    localparam logic [9:0] ADDR_IND3_CFG = 10'h306;
    localparam logic [9:0] ADDR_CLK_STATUS = 10'h308;
    localparam logic [9:0] ADDR_LEVEL_A = 10'h30b;
    localparam logic [9:0] ADDR_LEVEL_B = 10'h30c;
    localparam logic [9:0] ADDR_IO_CFG = 10'h302;
    localparam logic [15:0] RST_IND3_CFG = 16'h0008;
    localparam logic [15:0] RST_CLK_STATUS = 16'h0002;
    localparam logic [15:0] RST_LEVEL_A = 16'h3c00;
    localparam logic [15:0] RST_LEVEL_B = 16'h0410;
    localparam logic [15:0] RST_IO_CFG = 16'h0000;
    localparam int IO_OWNER_BIT = 6;
    localparam logic [2:0] SRC_NORMAL = 3'h0;
    localparam logic [2:0] SRC_WOL = 3'h2;
    localparam logic [2:0] SRC_CRS_A = 3'h3;
    localparam logic [2:0] SRC_IRQ = 3'h4;
    localparam logic [2:0] SRC_CRS_B = 3'h5;
    localparam logic [2:0] SRC_CRS_C = 3'h6;
    localparam logic [2:0] SRC_HIGH = 3'h7;
    localparam logic [1:0] SYM_ZERO = 2'h0;
    localparam logic [1:0] SYM_PLUS = 2'h1;
    localparam logic [1:0] SYM_MINUS = 2'h2;
endpackage : lld_pkg

// ### hdl/lld_level_sel.sv
// picks the dac code for one mlt-3 symbol
// assumes symbol and crossover state come from the same clock domain
`timescale 1ns/100ps
module lld_level_sel
    import lld_pkg::*;
(
    input wire logic [1:0] symbol_i,
    input wire logic mdix_i,
    input wire logic [5:0] zero_code_i,
    input wire logic [5:0] plus_mdi_i,
    input wire logic [5:0] plus_mdix_i,
    input wire logic [5:0] minus_mdi_i,
    input wire logic [5:0] minus_mdix_i,
    output logic [5:0] code_o
);
    always_comb begin
        unique case (symbol_i)
            SYM_PLUS: code_o = mdix_i ? plus_mdix_i : plus_mdi_i;
            SYM_MINUS: code_o = mdix_i ? minus_mdix_i : minus_mdi_i;
            default: code_o = zero_code_i;
        endcase
    end
endmodule : lld_level_sel

// ### test/lld_tb.sv
// self-checking bench for the indicator 3 and line level register group
// assumes lld_regs answers reads one cycle after the strobe
`timescale 1ns/100ps
module testbench
    import lld_pkg::*;
;
    logic ref_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, mdix_i = 0;
    logic ind3_normal_i = 0, wol_i = 0, crs_i = 0, irq_i = 0, ref_clock_25m_i = 0;
    logic [9:0] addr_i = '0;
    logic [15:0] wdata_i = '0, rdata_o, rv;
    logic [1:0] symbol_i = '0;
    logic indicator_pin_3_o, ref_clock_25m_output_o, ref_clock_25m_output_oe_o;
    logic [5:0] dac_code_o, ex;
    int fails = 0, comparisons = 0, cycles = 0;
    lld_regs DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ind3_normal_i(ind3_normal_i),
        .wol_i(wol_i), .crs_i(crs_i), .irq_i(irq_i), .ref_clock_25m_i(ref_clock_25m_i),
        .symbol_i(symbol_i), .mdix_i(mdix_i), .indicator_pin_3_o(indicator_pin_3_o),
        .ref_clock_25m_output_o(ref_clock_25m_output_o),
        .ref_clock_25m_output_oe_o(ref_clock_25m_output_oe_o), .dac_code_o(dac_code_o));
    always #5 ref_clk_i = ~ref_clk_i;
    task automatic final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : settle
    task automatic test_reset_values;
        rd(ADDR_IND3_CFG, rv);
        chk("ind3_cfg", 16'h0008, rv);
        rd(ADDR_CLK_STATUS, rv);
        chk("clk_status", 16'h0002, rv);
        rd(ADDR_LEVEL_A, rv);
        chk("level_a", 16'h3c00, rv);
        rd(ADDR_LEVEL_B, rv);
        chk("level_b", 16'h0410, rv);
        rd(10'h3ff, rv);
        chk("unmapped", 16'h0000, rv);
        chk("oe", 16'h0001, {15'h0000, ref_clock_25m_output_oe_o});
        $display("test reset values done");
    endtask : test_reset_values
    task automatic test_access;
        wr(ADDR_IND3_CFG, 16'hffff);
        rd(ADDR_IND3_CFG, rv);
        chk("ind3_cfg", 16'h0038, rv);
        wr(ADDR_LEVEL_A, 16'hffff);
        rd(ADDR_LEVEL_A, rv);
        chk("level_a", 16'h3fff, rv);
        @(posedge ref_clk_i);
        ref_clock_25m_i <= 1'b1;
        settle(1);
        chk("ref clk pin", 16'h0001, {15'h0000, ref_clock_25m_output_o});
        wr(ADDR_IO_CFG, 16'hffff);
        #1;
        chk("ref clk oe", 16'h0000, {15'h0000, ref_clock_25m_output_oe_o});
        chk("ref clk pin", 16'h0000, {15'h0000, ref_clock_25m_output_o});
        rd(ADDR_IO_CFG, rv);
        chk("io_cfg", 16'h0040, rv);
        rd(ADDR_CLK_STATUS, rv);
        chk("clk_status", 16'h0003, rv);
        wr(ADDR_CLK_STATUS, 16'h0000);
        rd(ADDR_CLK_STATUS, rv);
        chk("clk_status", 16'h0001, rv);
        wr(ADDR_IO_CFG, 16'h0000);
        #1;
        chk("ref clk oe", 16'h0001, {15'h0000, ref_clock_25m_output_oe_o});
        rd(ADDR_CLK_STATUS, rv);
        chk("clk_status", 16'h0000, rv);
        $display("test access done");
    endtask : test_access
    task automatic test_levels;
        wr(ADDR_LEVEL_A, 16'h3a85);
        wr(ADDR_LEVEL_B, 16'h5317);
        rd(ADDR_LEVEL_B, rv);
        chk("level_b", 16'h5317, rv);
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge ref_clk_i);
                symbol_i <= s[1:0];
                mdix_i <= m[0];
                settle(1);
                ex = (s == 1) ? (m ? 6'h0c : 6'h17) : (s == 2) ? (m ? 6'h35 : 6'h2a) : 6'h05;
                chk("dac code", {10'h000, ex}, {10'h000, dac_code_o});
            end
        end
        @(posedge ref_clk_i);
        symbol_i <= SYM_MINUS;
        settle(1);
        chk("minus mdix code", 16'h0035, {10'h000, dac_code_o});
        $display("test levels done");
    endtask : test_levels
    task automatic test_pin3;
        @(posedge ref_clk_i);
        ind3_normal_i <= 1'b1;
        settle(2);
        chk("pin3", 16'h0001, {15'h0000, indicator_pin_3_o});
        @(posedge ref_clk_i);
        ind3_normal_i <= 1'b0;
        wol_i <= 1'b1;
        crs_i <= 1'b1;
        irq_i <= 1'b1;
        settle(4);
        chk("pin3", 16'h0000, {15'h0000, indicator_pin_3_o});
        $display("test pin3 done");
    endtask : test_pin3
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        test_reset_values();
        test_access();
        test_levels();
        test_pin3();
        final_report();
    end
endmodule : testbench
